// ---- rtl/asu_uart.sv ----
// Summary of operation
// [R1] receive timing restarts on start-bit falling edge
// [R2] one start bit, 7, 8 or 9 data bits
// [R3] optional odd or even parity bit
// [R4] one or two stop bits at idle level
// [R5] internal rate is prescaled clock over 16(m+1)
// [R6] external rate is pin clock over 16(m+1)
// [R7] flow control: cts, rts, both or none
// [R8] transmit needs allow bit and full buffer
// [R9] cts selected: start only while pin low
// [R10] receive needs allow bit and start bit
// [R11] irq select 0: interrupt on buffer transfer
// [R12] irq select 1: interrupt on shift done
// [R13] receive interrupt on holding buffer load
// [R14] overrun checked at bit before stop; with two stop bits the code checks at the first stop bit
// [R15] missing stop bit sets framing error
// [R16] parity mismatch sets parity error
// [R17] software enables parity to use checking
// [R18] error summary is or of errors
// [R19] lsb or msb first selectable
// [R20] data inversion leaves start and stop
// [R21] line polarity inverts every level
// [R22] transmit line idles high or released
// [R23] mode codes 100b, 101b, 110b
// [R24] overrun: no load, no receive interrupt
// [R25] software keeps lsb first for 7/9 bits
// [R26] sample mid-bit, confirm start still low
// [R27] holding buffer uses low character bits
//
// The strobed register port and the register addresses are this design's own decisions.
module asu_uart import asu_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // serial pins
  input wire logic rxIn,
  output logic txOut,
  output logic txOutEn,
  input wire logic clearToSendPinN,
  output logic readyToSendPinN,
  input wire logic externalBitClockPin,
  // interrupt requests
  output logic txIrq,
  output logic rxIrq
);
  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  logic [7:0] serialMode_q;
  logic [7:0] auxSerialControl_q;
  logic [7:0] baudDivisor_q;
  logic txAllowBit_q;
  logic rxAllowBit_q;
  logic [8:0] txHoldingBuffer_q;
  logic txBufferEmptyFlag_q;
  logic [8:0] rxHoldingBuffer_q;
  logic rxFull_q;
  logic overrunFlag_q;
  logic framingErrorFlag_q;
  logic parityFailFlag_q;
  logic [15:0] rdData_q;
  logic [2:0] pinLevel;
  logic osTick;
  logic [2:0] serialModeField;
  logic asyncOn;
  logic [3:0] charLen;
  logic [8:0] charMask;
  logic stop2;
  logic parEn;
  logic parOdd;
  logic lineInvert;
  logic msbFirst;
  logic dataInvert;
  logic ctsEn;
  logic rtsEn;
  logic wrTx;
  logic rdRx;

  assign serialModeField = serialMode_q[MR_SMD_LSB+:3];
  assign asyncOn = serialModeField inside {SMD_ASYNC7, SMD_ASYNC8, SMD_ASYNC9}; // [R23]
  assign charLen = serialModeField == SMD_ASYNC7 ? LEN7 :
                   serialModeField == SMD_ASYNC8 ? LEN8 : LEN9; // [R2]
  assign charMask = serialModeField == SMD_ASYNC7 ? 9'h07f :
                    serialModeField == SMD_ASYNC8 ? 9'h0ff : 9'h1ff;
  assign stop2 = serialMode_q[MR_STOP2];
  assign parEn = serialMode_q[MR_PAR_EN];
  assign parOdd = serialMode_q[MR_PAR_ODD];
  assign lineInvert = serialMode_q[MR_POL];
  assign msbFirst = auxSerialControl_q[C0_MSB];
  assign dataInvert = auxSerialControl_q[C0_INV];
  assign ctsEn = auxSerialControl_q[C0_CTS]; // [R7]
  assign rtsEn = auxSerialControl_q[C0_RTS]; // [R7]
  assign wrTx = regWrite && regAddr == ADDR_TXBUF;
  assign rdRx = regRead && regAddr == ADDR_RXBUF;

  // character bit index after order selection; 7/9-bit msb-first is left to software
  function automatic logic [3:0] bitPos(input logic [3:0] idx, input logic msb,
                                        input logic [3:0] len);
    bitPos = msb ? len - 4'h1 - idx : idx; // [R19]
  endfunction

  asu_sync uSync (
    .clock(clock),
    .reset(reset),
    .pinIn({externalBitClockPin, clearToSendPinN, rxIn}),
    .pinOut(pinLevel)
  );

  asu_baud_gen uBaud (
    .clock(clock),
    .reset(reset),
    .extSource(serialMode_q[MR_CKSRC]),
    .prescaleSel(auxSerialControl_q[C0_PRE_LSB+:2]),
    .divisor(baudDivisor_q),
    .extClkLevel(pinLevel[2]),
    .osTick(osTick)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      serialMode_q <= MODE_RESET;
      auxSerialControl_q <= CTRL0_RESET;
      baudDivisor_q <= BAUD_RESET;
      txAllowBit_q <= 1'b0;
      rxAllowBit_q <= 1'b0;
    end else if (regWrite) begin
      if (regAddr == ADDR_MODE) serialMode_q <= regWrData[7:0];
      if (regAddr == ADDR_CTRL0) auxSerialControl_q <= regWrData[7:0];
      if (regAddr == ADDR_BAUD) baudDivisor_q <= regWrData[7:0];
      if (regAddr == ADDR_CTRL1) begin
        txAllowBit_q <= regWrData[C1_TXA];
        rxAllowBit_q <= regWrData[C1_RXA];
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  asu_state_t txState_q;
  logic [3:0] txPhase_q;
  logic [3:0] txIdx_q;
  logic [8:0] txShift_q;
  logic txLine_q;
  logic txOut_q;
  logic txOutEn_q;
  logic txIrq_q;
  logic txGo;
  logic txBitEnd;
  logic txDone;
  logic txLastData;
  logic txParBit;

  assign txGo = asyncOn && txState_q == ST_IDLE && txAllowBit_q && !txBufferEmptyFlag_q // [R8]
                && (!ctsEn || !pinLevel[1]); // [R9]
  assign txBitEnd = osTick && txPhase_q == PHASE_LAST;
  assign txLastData = txIdx_q == charLen - 4'h1;
  assign txDone = txBitEnd && ((txState_q == ST_STOP1 && !stop2) || txState_q == ST_STOP2);
  assign txParBit = (^((txShift_q ^ {9{dataInvert}}) & charMask)) ^ parOdd; // [R3]

  always_ff @(posedge clock) begin
    if (reset) begin
      txHoldingBuffer_q <= 9'h000;
      txBufferEmptyFlag_q <= 1'b1;
    end else if (wrTx) begin
      txHoldingBuffer_q <= regWrData[8:0];
      txBufferEmptyFlag_q <= 1'b0;
    end else if (txGo) begin
      txBufferEmptyFlag_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      txState_q <= ST_IDLE;
      txPhase_q <= 4'h0;
      txIdx_q <= 4'h0;
      txShift_q <= 9'h000;
      txLine_q <= 1'b1;
    end else if (!asyncOn) begin
      txState_q <= ST_IDLE;
      txLine_q <= 1'b1;
    end else begin
      if (osTick) txPhase_q <= txPhase_q + 4'h1;
      unique case (txState_q)
        ST_IDLE: begin
          if (txGo) begin
            txState_q <= ST_START;
            txPhase_q <= 4'h0;
            txShift_q <= txHoldingBuffer_q;
            txLine_q <= 1'b0; // [R2]
          end
        end
        ST_START: begin
          if (txBitEnd) begin
            txState_q <= ST_DATA;
            txIdx_q <= 4'h0;
            txLine_q <= txShift_q[bitPos(4'h0, msbFirst, charLen)] ^ dataInvert; // [R20]
          end
        end
        ST_DATA: begin
          if (txBitEnd && txLastData) begin
            txState_q <= parEn ? ST_PAR : ST_STOP1;
            txLine_q <= parEn ? txParBit : 1'b1; // [R3]
          end else if (txBitEnd) begin
            txIdx_q <= txIdx_q + 4'h1;
            txLine_q <= txShift_q[bitPos(txIdx_q + 4'h1, msbFirst, charLen)] ^ dataInvert;
          end
        end
        ST_PAR: begin
          if (txBitEnd) begin
            txState_q <= ST_STOP1;
            txLine_q <= 1'b1; // [R4]
          end
        end
        ST_STOP1: begin
          if (txBitEnd) txState_q <= stop2 ? ST_STOP2 : ST_IDLE; // [R4]
        end
        ST_STOP2: begin
          if (txBitEnd) txState_q <= ST_IDLE;
        end
      endcase
    end
  end

  // open drain only pulls low, so an idle high line is released
  always_ff @(posedge clock) begin
    if (reset) begin
      txOut_q <= 1'b1;
      txOutEn_q <= 1'b1;
    end else begin
      txOut_q <= txLine_q ^ lineInvert; // [R21]
      txOutEn_q <= !auxSerialControl_q[C0_OD] || !(txLine_q ^ lineInvert); // [R22]
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      txIrq_q <= 1'b0;
    end else begin
      txIrq_q <= auxSerialControl_q[C0_IRS] ? txDone : txGo; // [R11] [R12]
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  asu_state_t rxState_q;
  logic [3:0] rxPhase_q;
  logic [3:0] rxIdx_q;
  logic [8:0] rxData_q;
  logic rxParAcc_q;
  logic rxParErr_q;
  logic rxFerr_q;
  logic rxOvrFrame_q;
  logic rxPrev_q;
  logic rxIrq_q;
  logic rts_q;
  logic rxLine;
  logic rxSample;
  logic rxOvrPoint;
  logic rxFinish;
  logic rxLoad;
  logic rxFerNow;

  assign rxLine = pinLevel[0] ^ lineInvert; // [R21]
  assign rxSample = osTick && rxPhase_q == RX_SAMPLE_PHASE; // [R26]
  assign rxFinish = rxSample && ((rxState_q == ST_STOP1 && !stop2) || rxState_q == ST_STOP2);
  assign rxFerNow = !rxLine || (rxState_q == ST_STOP2 && rxFerr_q); // [R15]
  assign rxOvrPoint = rxSample && rxFull_q && (stop2 ? rxState_q == ST_STOP1 :
                      (rxState_q == ST_PAR ||
                      (rxState_q == ST_DATA && rxIdx_q == charLen - 4'h1 && !parEn))); // [R14]
  assign rxLoad = rxFinish && !rxOvrFrame_q && !rxOvrPoint; // [R24]

  always_ff @(posedge clock) begin
    if (reset) begin
      rxState_q <= ST_IDLE;
      rxPhase_q <= 4'h0;
      rxIdx_q <= 4'h0;
      rxData_q <= 9'h000;
      rxParAcc_q <= 1'b0;
      rxParErr_q <= 1'b0;
      rxFerr_q <= 1'b0;
      rxOvrFrame_q <= 1'b0;
      rxPrev_q <= 1'b1;
    end else begin
      rxPrev_q <= rxLine;
      if (osTick) rxPhase_q <= rxPhase_q + 4'h1;
      if (rxOvrPoint) rxOvrFrame_q <= 1'b1;
      unique case (rxState_q)
        ST_IDLE: begin
          if (asyncOn && rxAllowBit_q && rxPrev_q && !rxLine) begin // [R10]
            rxState_q <= ST_START;
            rxPhase_q <= 4'h0; // [R1]
            rxData_q <= 9'h000; // [R27]
            rxParAcc_q <= 1'b0;
            rxParErr_q <= 1'b0;
            rxFerr_q <= 1'b0;
            rxOvrFrame_q <= 1'b0;
          end
        end
        ST_START: begin
          if (rxSample) begin
            rxState_q <= rxLine ? ST_IDLE : ST_DATA; // [R26]
            rxIdx_q <= 4'h0;
          end
        end
        ST_DATA: begin
          if (rxSample) begin
            rxData_q[bitPos(rxIdx_q, msbFirst, charLen)] <= rxLine ^ dataInvert; // [R19] [R20]
            rxParAcc_q <= rxParAcc_q ^ rxLine;
            rxIdx_q <= rxIdx_q + 4'h1;
            if (rxIdx_q == charLen - 4'h1) rxState_q <= parEn ? ST_PAR : ST_STOP1;
          end
        end
        ST_PAR: begin
          if (rxSample) begin
            rxParErr_q <= (rxParAcc_q ^ rxLine) != parOdd; // [R16]
            rxState_q <= ST_STOP1;
          end
        end
        ST_STOP1: begin
          if (rxSample) begin
            rxFerr_q <= !rxLine;
            rxState_q <= stop2 ? ST_STOP2 : ST_IDLE;
          end
        end
        ST_STOP2: begin
          if (rxSample) rxState_q <= ST_IDLE;
        end
      endcase
    end
  end

  // a read clears the flags, but an event in the same cycle still wins
  always_ff @(posedge clock) begin
    if (reset) begin
      rxHoldingBuffer_q <= 9'h000;
      rxFull_q <= 1'b0;
      overrunFlag_q <= 1'b0;
      framingErrorFlag_q <= 1'b0;
      parityFailFlag_q <= 1'b0;
    end else begin
      if (rdRx) begin
        rxFull_q <= 1'b0;
        overrunFlag_q <= 1'b0;
        framingErrorFlag_q <= 1'b0;
        parityFailFlag_q <= 1'b0;
      end
      if (rxOvrPoint) overrunFlag_q <= 1'b1; // [R14]
      if (rxLoad) begin
        rxHoldingBuffer_q <= rxData_q & charMask; // [R27]
        rxFull_q <= 1'b1;
        if (rxFerNow) framingErrorFlag_q <= 1'b1; // [R15]
        if (parEn && rxParErr_q) parityFailFlag_q <= 1'b1; // [R16]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rxIrq_q <= 1'b0;
      rts_q <= 1'b1;
    end else begin
      rxIrq_q <= rxLoad; // [R13]
      rts_q <= !(rtsEn && asyncOn && rxAllowBit_q && !rxFull_q); // [R7]
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      rdData_q <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_MODE: rdData_q <= {8'h00, serialMode_q};
        ADDR_CTRL0: rdData_q <= {8'h00, auxSerialControl_q};
        ADDR_CTRL1: rdData_q <= {11'h000, txState_q == ST_IDLE, rxFull_q,
                                 txBufferEmptyFlag_q, rxAllowBit_q, txAllowBit_q};
        ADDR_BAUD: rdData_q <= {8'h00, baudDivisor_q};
        ADDR_TXBUF: rdData_q <= {7'h00, txHoldingBuffer_q};
        ADDR_RXBUF: rdData_q <= {overrunFlag_q | framingErrorFlag_q | parityFailFlag_q, // [R18]
                                 parityFailFlag_q, framingErrorFlag_q, overrunFlag_q,
                                 3'h0, rxHoldingBuffer_q};
        default: rdData_q <= 16'h0000;
      endcase
    end else begin
      rdData_q <= 16'h0000;
    end
  end

  assign regRdData = rdData_q;
  assign txOut = txOut_q;
  assign txOutEn = txOutEn_q;
  assign readyToSendPinN = rts_q;
  assign txIrq = txIrq_q;
  assign rxIrq = rxIrq_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence seqTxLaunch;
    txGo ##1 (txState_q == ST_START && !txLine_q);
  endsequence

  sequence seqRxDone;
    rxLoad ##1 (rxIrq_q && rxFull_q);
  endsequence

  AST_TX_START: assert property ($rose(txState_q == ST_START) |-> $past(txGo)) // [R8]
    else $error("frame started without start conditions");
  AST_TX_LAUNCH: assert property (txGo |-> seqTxLaunch) // [R2]
    else $error("start bit not driven after launch");
  AST_CTS_HOLD: assert property (ctsEn && pinLevel[1] |-> !txGo) // [R9]
    else $error("transmit started while cts high");
  AST_TX_IRQ0: assert property (txGo && !auxSerialControl_q[C0_IRS] |=> // [R11]
    txIrq_q ##1 !txIrq_q)
    else $error("buffer transfer interrupt missing");
  AST_TX_IRQ1: assert property (txDone && auxSerialControl_q[C0_IRS] |=> txIrq_q) // [R12]
    else $error("shift done interrupt missing");
  AST_RX_IRQ: assert property (rxIrq_q |-> $past(rxLoad)) // [R13]
    else $error("receive interrupt without load");
  AST_RX_LOAD: assert property (rxLoad |-> seqRxDone) // [R13]
    else $error("load did not raise interrupt and full");
  AST_OVR_NOIRQ: assert property (rxFinish && rxOvrFrame_q |=> !rxIrq_q) // [R24]
    else $error("interrupt raised on overrun");
  AST_OVR_SET: assert property (rxOvrPoint |=> overrunFlag_q) // [R14]
    else $error("overrun flag not set");
  AST_RX_BEGIN: assert property ($rose(rxState_q == ST_START) |-> $past(rxAllowBit_q)) // [R10]
    else $error("reception began while disabled");
  AST_START_FALSE: assert property (rxState_q == ST_START && rxSample && rxLine // [R26]
    |=> rxState_q == ST_IDLE)
    else $error("false start bit not rejected");
  AST_ERR_SUM: assert property (rdRx |=> // [R18]
    regRdData[RB_OVR+3] == (|regRdData[RB_OVR+:3]))
    else $error("error summary mismatch");
  AST_TX_IDLE_HIGH: assert property (txState_q == ST_IDLE ##1 txState_q == ST_IDLE // [R22]
    |-> txLine_q)
    else $error("idle transmit line not high");
endmodule // asu_uart

// ---- rtl/asu_pkg.sv ----
package asu_pkg;
  // ----------------------------------------
  // register offsets (word index on a plain port)
  // ----------------------------------------
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CTRL0 = 3'h1;
  localparam logic [2:0] ADDR_CTRL1 = 3'h2;
  localparam logic [2:0] ADDR_BAUD = 3'h3;
  localparam logic [2:0] ADDR_TXBUF = 3'h4;
  localparam logic [2:0] ADDR_RXBUF = 3'h5;
  // ----------------------------------------
  // serial_mode_reg fields
  // ----------------------------------------
  localparam int MR_SMD_LSB = 0;
  localparam int MR_CKSRC = 3;
  localparam int MR_STOP2 = 4;
  localparam int MR_PAR_ODD = 5;
  localparam int MR_PAR_EN = 6;
  localparam int MR_POL = 7;
  localparam logic [2:0] SMD_ASYNC7 = 3'h4;
  localparam logic [2:0] SMD_ASYNC8 = 3'h5;
  localparam logic [2:0] SMD_ASYNC9 = 3'h6;
  // ----------------------------------------
  // aux_serial_control, serial_control_one and receive buffer fields
  // ----------------------------------------
  localparam int C0_PRE_LSB = 0;
  localparam int C0_CTS = 2;
  localparam int C0_RTS = 3;
  localparam int C0_MSB = 4;
  localparam int C0_INV = 5;
  localparam int C0_IRS = 6;
  localparam int C0_OD = 7;
  localparam int C1_TXA = 0;
  localparam int C1_RXA = 1;
  localparam int RB_OVR = 12;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [2:0] SYNC_INIT = 3'h3;
  localparam logic [4:0] PRE_F8_MASK = 5'h07;
  localparam logic [4:0] PRE_F2N_MASK = 5'h1f;
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [3:0] RX_SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] LEN7 = 4'h7;
  localparam logic [3:0] LEN8 = 4'h8;
  localparam logic [3:0] LEN9 = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP1 = 3'b100,
    ST_STOP2 = 3'b101
  } asu_state_t;
endpackage

// ---- rtl/asu_sync.sv ----
module asu_sync import asu_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // raw pins and filtered levels
  input wire logic [2:0] pinIn,
  output logic [2:0] pinOut
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] out_q;

  // level only moves once stages two and three agree, filtering one-cycle glitches
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : gBit
      always_ff @(posedge clock) begin
        if (reset) begin
          s1_q[i] <= SYNC_INIT[i];
          s2_q[i] <= SYNC_INIT[i];
          s3_q[i] <= SYNC_INIT[i];
          out_q[i] <= SYNC_INIT[i];
        end else begin
          s1_q[i] <= pinIn[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            out_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

  assign pinOut = out_q;
endmodule // asu_sync

// ---- rtl/asu_baud_gen.sv ----
module asu_baud_gen import asu_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // configuration
  input wire logic extSource,
  input wire logic [1:0] prescaleSel,
  input wire logic [7:0] divisor,
  // filtered external clock level
  input wire logic extClkLevel,
  // sixteen-times bit rate tick
  output logic osTick
);
  logic [4:0] pre_q;
  logic extPrev_q;
  logic [7:0] div_q;
  logic osTick_q;
  logic srcTick;

  always_ff @(posedge clock) begin
    if (reset) begin
      pre_q <= 5'h00;
      extPrev_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 5'h01;
      extPrev_q <= extClkLevel;
    end
  end

  always_comb begin
    if (extSource) begin
      srcTick = extClkLevel & ~extPrev_q; // [R6]
    end else begin
      unique case (prescaleSel)
        2'h0: srcTick = 1'b1;
        2'h1: srcTick = (pre_q & PRE_F8_MASK) == PRE_F8_MASK;
        default: srcTick = pre_q == PRE_F2N_MASK;
      endcase
    end
  end

  // divide by divisor plus one; >= keeps the count sane if software lowers it mid-run
  always_ff @(posedge clock) begin
    if (reset) begin
      div_q <= 8'h00;
      osTick_q <= 1'b0;
    end else begin
      osTick_q <= 1'b0;
      if (srcTick) begin
        if (div_q >= divisor) begin // [R5]
          div_q <= 8'h00;
          osTick_q <= 1'b1;
        end else begin
          div_q <= div_q + 8'h01;
        end
      end
    end
  end

  assign osTick = osTick_q;
endmodule // asu_baud_gen

// ---- tb/asu_remote_peer.sv ----
module asu_remote_peer (
  // clock
  input wire logic clock,
  // serial lines
  input wire logic txOut,
  output logic rxIn,
  output logic clearToSendPinN
);
  timeunit 1ns;
  timeprecision 1ns;
  int bitClks = 16;
  logic pol = 1'b0;
  logic ctsQ = 1'b0;
  initial rxIn = 1'b1;
  assign clearToSendPinN = ctsQ;
  // ----------------------------------------
  // line level and frames into the device
  // ----------------------------------------
  task automatic idle(input logic p);
    pol = p;
    rxIn <= ~p;
  endtask
  task automatic send(input logic [15:0] f, input int n);
    for (int k = 0; k < n; k++) begin
      rxIn <= f[k] ^ pol;
      repeat (bitClks) @(posedge clock);
    end
    rxIn <= ~pol;
    repeat (2 * bitClks) @(posedge clock);
  endtask
  // ----------------------------------------
  // frames out of the device, sampled mid-bit
  // ----------------------------------------
  task automatic grab(input int n, output logic [15:0] f);
    int w;
    w = 0;
    f = 'x;
    while (txOut !== pol && w < 20000) begin
      @(negedge clock);
      w++;
    end
    if (w < 20000) begin
      f = '1;
      repeat (bitClks / 2) @(negedge clock);
      for (int k = 0; k < n; k++) begin
        f[k] = txOut ^ pol;
        repeat (bitClks) @(negedge clock);
      end
    end
  endtask
endmodule // asu_remote_peer

// ---- tb/asu_uart_bench.sv ----
module asu_uart_bench import asu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset = 1, regWrite = 0, regRead = 0, odQ = 0;
  logic [2:0] regAddr = '0;
  logic [15:0] regWrData = '0, regRdData, v, f, ex, fr;
  logic [1:0] ph = '0, src;
  logic txOut, txOutEn, rxIn, ctsN, rtsN, txIrq, rxIrq;
  logic par, odd, two, msb, inv, pol, irs, od, m, fe, pe;
  logic [8:0] d;
  logic [31:0] r;
  int n_errors = 0, num_checks = 0, seed = 7, txCnt = 0, rxCnt = 0, c, len, n;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    ph <= ph + 2'h1;
    if (txIrq === 1'b1) txCnt++;
    if (rxIrq === 1'b1) rxCnt++;
  end
  always @(negedge clock) if (odQ) chk({15'h0, txOutEn}, {15'h0, ~txOut});
  asu_uart u_asu_uart (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .rxIn(rxIn), .txOut(txOut), .txOutEn(txOutEn), .clearToSendPinN(ctsN),
    .readyToSendPinN(rtsN), .externalBitClockPin(ph[1]), .txIrq(txIrq), .rxIrq(rxIrq));
  asu_remote_peer u_asu_remote_peer (.clock(clock), .txOut(txOut), .rxIn(rxIn),
    .clearToSendPinN(ctsN));
  // ----------------------------------------
  // bus, compare and expectation helpers
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [15:0] w);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= w;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] q);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 q = regRdData;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] frame(logic [8:0] dd, int ln);
    logic [15:0] q;
    logic p;
    q = '1;
    q[0] = 1'b0;
    p = odd;
    for (int k = 0; k < ln; k++) begin
      q[k + 1] = (msb ? dd[ln - 1 - k] : dd[k]) ^ inv;
      p ^= q[k + 1];
    end
    if (par) q[ln + 1] = p;
    return q;
  endfunction
  task automatic cfg(input logic [1:0] flow);
    odQ = 1'b0;
    wr(ADDR_CTRL1, 16'h0);
    u_asu_remote_peer.idle(pol);
    wr(ADDR_MODE, {8'h0, pol, par, odd, two, src == 2'h2,
      len == 7 ? SMD_ASYNC7 : len == 8 ? SMD_ASYNC8 : SMD_ASYNC9});
    wr(ADDR_CTRL0, {8'h0, od, irs, inv, msb, flow, src == 2'h1 ? 2'h1 : 2'h0});
    wr(ADDR_BAUD, {15'h0, m});
    repeat (40) @(posedge clock);
    rd(ADDR_RXBUF, v);
    wr(ADDR_CTRL1, 16'h3);
    u_asu_remote_peer.bitClks = 16 * (m + 1) * (src == 2'h1 ? 8 : src == 2'h2 ? 4 : 1);
    n = 2 + len + par + two;
    @(posedge clock);
    odQ = od;
  endtask
  task tally_and_finish;
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    #400000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    #1 chk({13'h0, txOut, txOutEn, rtsN}, 16'h7);
    rd(ADDR_CTRL1, v);
    chk(v, 16'h0014);
    wr(3'h7, 16'hffff);
    rd(3'h7, v);
    chk(v, 16'h0);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      len = r[1:0] == 2'h3 ? 8 : 7 + r[1:0];
      {par, odd, two, inv, pol, irs, od} = r[8:2];
      msb = (len == 8) & r[9];
      src = r[11:10] == 2'h3 ? 2'h0 : r[11:10];
      m = r[12] & (src != 2'h1);
      d = r[31:23];
      cfg(2'h0);
      ex = frame(d, len);
      c = txCnt;
      wr(ADDR_TXBUF, {7'h0, d});
      repeat (6) @(posedge clock);
      chk(16'(txCnt - c), irs ? 16'h0 : 16'h1);
      u_asu_remote_peer.grab(n, f);
      chk(f, ex);
      repeat (2 * u_asu_remote_peer.bitClks) @(posedge clock);
      chk(16'(txCnt - c), 16'h1);
      pe = (r[14:13] == 2'h1) & par;
      fe = r[14:13] == 2'h2;
      fr = ex;
      if (pe) fr[len + 1] = ~fr[len + 1];
      if (fe) fr[n - 1] = 1'b0;
      c = rxCnt;
      u_asu_remote_peer.send(fr, n);
      chk(16'(rxCnt - c), 16'h1);
      rd(ADDR_RXBUF, v);
      chk(v, {fe | pe, pe, fe, 4'h0, d & (9'h1ff >> (9 - len))});
    end
    {par, odd, two, inv, pol, irs, od, msb, src, m, len} = {11'h0, 8};
    cfg(2'h2);
    repeat (6) @(posedge clock);
    chk({15'h0, rtsN}, 16'h0);
    c = rxCnt;
    u_asu_remote_peer.send(frame(9'h0a5, 8), n);
    chk({15'h0, rtsN}, 16'h1);
    u_asu_remote_peer.send(frame(9'h03c, 8), n);
    rd(ADDR_RXBUF, v);
    chk({v[15:12], 12'(rxCnt - c)}, {4'h9, 12'h001});
    cfg(2'h1);
    wr(ADDR_CTRL1, 16'h2);
    u_asu_remote_peer.ctsQ <= 1'b1;
    wr(ADDR_TXBUF, 16'h005a);
    repeat (64) @(posedge clock);
    rd(ADDR_CTRL1, v);
    chk({14'h0, txOut, v[2]}, 16'h2);
    wr(ADDR_CTRL1, 16'h3);
    repeat (64) @(posedge clock);
    chk({15'h0, txOut}, 16'h1);
    u_asu_remote_peer.ctsQ <= 1'b0;
    u_asu_remote_peer.grab(n, f);
    chk(f, frame(9'h05a, 8));
    tally_and_finish;
  end
endmodule // asu_uart_bench
